// ==== logic/cdc_filter.sv ====
// majority-free glitch filter: passes a level stable for N ticks
`timescale 1ns/1ps
module cdc_filter (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// sample strobe and data
	input wire logic tick_i,
	input wire logic level_i,
	output logic level_o
);
	typedef struct packed {
		logic [1:0] run;
		logic out;
	} cdc_flt_state_t;
	cdc_flt_state_t s_q;
	cdc_flt_state_t s_d;
	always_comb begin
		s_d = s_q;
		if (tick_i) begin
			if (level_i == s_q.out) begin
				s_d.run = 2'h0;
			end else if (s_q.run == 2'(cdc_pkg::FILTER_SAMPLES - 1)) begin
				s_d.out = level_i; // [R3]
				s_d.run = 2'h0;
			end else begin
				s_d.run = s_q.run + 2'h1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign level_o = s_q.out;
endmodule

// ==== logic/cdc_pkg.sv ====
// shared constants for the comparator digital control block
package cdc_pkg;
	// register byte addresses
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] THRESH_ADDR = 12'h004;
	localparam logic [11:0] OUTCTL_ADDR = 12'h008;
	// control register fields
	localparam int CHANNEL_ON_BIT = 15;
	localparam int HALT_WHEN_IDLE_BIT = 13;
	localparam int HYST_LEVEL_HI = 12;
	localparam int HYST_LEVEL_LO = 11;
	localparam int FILTER_ON_BIT = 10;
	localparam int FILTER_CLK_BIT = 9;
	localparam int REF_OUT_BIT = 8;
	localparam int INPUT_PICK_HI = 7;
	localparam int INPUT_PICK_LO = 6;
	localparam int OUTSIDE_REF_BIT = 5;
	localparam int HYST_EDGE_BIT = 4;
	localparam int STATE_BIT = 3;
	localparam int ALT_INPUT_BIT = 2;
	localparam int INVERT_BIT = 1;
	localparam int SPAN_BIT = 0;
	// bit 14 unused, bit 3 is hardware owned
	localparam logic [15:0] CTRL_WMASK = 16'hbff7;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [11:0] THRESH_RESET = 12'h000;
	// destination enables: irq, adc trigger, pwm duty, pwm period, fault latch
	localparam int DEST_W = 5;
	localparam logic [4:0] OUTCTL_RESET = 5'h00;
	localparam int DEST_FAULT = 4;
	// timing
	localparam int CLK_HZ = 10000000;
	localparam int STRETCH_CYCLES = 3;
	localparam int FILTER_SAMPLES = 3;
	localparam int FCLK_DIV = 4;
endpackage

// ==== logic/cdc_stretch.sv ====
// pulse stretcher: asynchronous set, held for a minimum number of ticks
`timescale 1ns/1ps
module cdc_stretch (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// tick selects the stretcher clock rate
	input wire logic tick_i,
	input wire logic pulse_i,
	output logic stretched_o
);
	typedef struct packed {
		logic [1:0] cnt;
		logic held;
	} cdc_str_state_t;
	cdc_str_state_t s_q;
	cdc_str_state_t s_d;
	logic set_q;
	// async set catches pulses narrower than a clock period [R2]
	always_ff @(posedge clk_i or posedge pulse_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			set_q <= 1'b0;
		end else if (pulse_i) begin
			set_q <= 1'b1;
		end else if (s_q.held) begin
			set_q <= 1'b0;
		end
	end
	always_comb begin
		s_d = s_q;
		if (set_q) begin
			s_d.held = 1'b1;
			s_d.cnt = 2'(cdc_pkg::STRETCH_CYCLES - 1);
		end else if (tick_i && s_q.cnt != 2'h0) begin
			s_d.cnt = s_q.cnt - 2'h1;
		end else if (tick_i) begin
			s_d.held = 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	// minimum width of three ticks [R2]
	assign stretched_o = set_q | s_q.held;
endmodule

// ==== logic/cdc_top.sv ====
// comparator channel digital control with apb register access
// Function
// R1 - polarity applied before the stretcher
// R2 - async set stretcher, three clock minimum
// R3 - filter passes level stable three clocks
// R4 - bit 10 inserts filter, else bypass
// R5 - bit 9 picks filter and stretcher clock
// R6 - hysteresis level field forwarded to analog
// R7 - bit 4 selects hysteresis edge
// R8 - state bit hardware owned, polarity corrected
// R9 - bit 1 inverts comparator output
// R10 - input pick routes a to d
// R11 - bit 2 selects alternate sources
// R12 - bit 5 picks outside reference
// R13 - software keeps span bit set
// R14 - one channel drives reference output
// R15 - 12-bit threshold feeds negative input
// R16 - output drives several destinations together
// R17 - comparator event wakes from sleep, idle
// R18 - bit 15 enables channel
// R19 - bit 13 halts channel during idle
`timescale 1ns/1ps
module cdc_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// system power state
	input wire logic idle_i,
	input wire logic sleep_i,
	// raw analog comparator result
	input wire logic compare_raw_i,
	// analog stage controls
	output logic analog_on_o,
	output logic [1:0] hysteresis_level_o,
	output logic hysteresis_edge_o,
	output logic [1:0] input_pick_o,
	output logic alternate_input_pick_o,
	output logic outside_reference_pick_o,
	output logic ref_out_drive_o,
	output logic span_o,
	output logic [11:0] threshold_code_o,
	// conditioned output and its destinations
	output logic compare_out_o,
	output logic irq_o,
	output logic adc_trigger_o,
	output logic pwm_duty_cut_o,
	output logic pwm_period_cut_o,
	output logic pwm_fault_o,
	output logic wake_o
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [11:0] thresh;
		logic [4:0] dest;
		logic [1:0] raw_sync;
		logic [1:0] div;
		logic fault;
		logic prev;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [21:0] ana;
		logic [5:0] outs;
	} cdc_state_t;
	cdc_state_t s_q;
	cdc_state_t s_d;
	logic running;
	logic tick;
	logic corrected;
	logic stretched;
	logic filtered;
	logic cond;
	logic setup;
	logic wr_done;
	logic [15:0] ctrl_rd;

	// halted when off, or idle with halt requested [R18] [R19]
	assign running = s_q.ctrl[cdc_pkg::CHANNEL_ON_BIT] &&
		!(idle_i && s_q.ctrl[cdc_pkg::HALT_WHEN_IDLE_BIT]);
	// clock pick: 1 runs on every cycle, 0 on the divided filter clock [R5]
	assign tick = s_q.ctrl[cdc_pkg::FILTER_CLK_BIT] || (s_q.div == 2'h0);
	// polarity first, gated by enable; raw input passes no synchroniser
	// because the stretcher must catch sub-cycle pulses [R1] [R9]
	assign corrected = running &&
		(compare_raw_i ^ s_q.ctrl[cdc_pkg::INVERT_BIT]);

	cdc_stretch u_stretch (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick),
		.pulse_i(corrected),
		.stretched_o(stretched)
	);

	cdc_filter u_filter (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick),
		.level_i(stretched),
		.level_o(filtered)
	);

	// filter inserted or bypassed [R4]
	assign cond = running &&
		(s_q.ctrl[cdc_pkg::FILTER_ON_BIT] ? filtered : stretched);
	assign setup = psel_i && !penable_i;
	// a write lands only at the edge that completes the access
	assign wr_done = psel_i && penable_i && pwrite_i && s_q.ready;

	always_comb begin
		ctrl_rd = s_q.ctrl;
		// live polarity-corrected state, never software written [R8]
		ctrl_rd[cdc_pkg::STATE_BIT] = s_q.raw_sync[1] ^ s_q.ctrl[cdc_pkg::INVERT_BIT];
	end

	always_comb begin
		s_d = s_q;
		s_d.div = 2'(s_q.div + 2'h1);
		if (s_q.div == 2'(cdc_pkg::FCLK_DIV - 1)) begin
			s_d.div = 2'h0;
		end
		s_d.raw_sync = {s_q.raw_sync[0], compare_raw_i};
		s_d.prev = cond;
		// fault latches until software clears its enable [R16]
		if (!s_q.dest[cdc_pkg::DEST_FAULT]) begin
			s_d.fault = 1'b0;
		end
		if (cond && s_q.dest[cdc_pkg::DEST_FAULT]) begin
			s_d.fault = 1'b1;
		end
		// answer in the access cycle after setup; read data captured at setup
		s_d.ready = 1'b0;
		s_d.err = 1'b0;
		if (setup) begin
			s_d.ready = 1'b1;
			s_d.rdata = 32'h0000_0000;
			unique case (paddr_i)
				cdc_pkg::CTRL_ADDR: begin
					s_d.rdata = {16'h0000, ctrl_rd};
				end
				cdc_pkg::THRESH_ADDR: begin
					s_d.rdata = {20'h00000, s_q.thresh};
				end
				cdc_pkg::OUTCTL_ADDR: begin
					s_d.rdata = {27'h0000000, s_q.dest};
				end
				default: begin
					s_d.err = 1'b1;
				end
			endcase
		end
		// unmapped addresses fall through with no write
		if (wr_done) begin
			unique case (paddr_i)
				cdc_pkg::CTRL_ADDR: begin
					s_d.ctrl = (pwdata_i[15:0] & cdc_pkg::CTRL_WMASK);
				end
				cdc_pkg::THRESH_ADDR: begin
					s_d.thresh = pwdata_i[11:0]; // [R15]
				end
				cdc_pkg::OUTCTL_ADDR: begin
					s_d.dest = pwdata_i[4:0];
				end
				default: begin
				end
			endcase
		end
		// analog settings forwarded [R6] [R7] [R10] [R11] [R12] [R15]
		s_d.ana = {running,
			s_q.ctrl[cdc_pkg::HYST_LEVEL_HI:cdc_pkg::HYST_LEVEL_LO],
			s_q.ctrl[cdc_pkg::HYST_EDGE_BIT],
			s_q.ctrl[cdc_pkg::INPUT_PICK_HI:cdc_pkg::INPUT_PICK_LO],
			s_q.ctrl[cdc_pkg::ALT_INPUT_BIT],
			s_q.ctrl[cdc_pkg::OUTSIDE_REF_BIT],
			s_q.ctrl[cdc_pkg::REF_OUT_BIT] && running, // [R14]
			s_q.ctrl[cdc_pkg::SPAN_BIT], // [R13]
			s_q.thresh};
		// destinations act concurrently [R16]; rising event wakes [R17]
		s_d.outs = {cond,
			cond && !s_q.prev && s_q.dest[0],
			cond && !s_q.prev && s_q.dest[1],
			cond && s_q.dest[2],
			cond && s_q.dest[3],
			cond && !s_q.prev && (sleep_i || idle_i)};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata_o = s_q.rdata;
	assign pready_o = s_q.ready;
	assign pslverr_o = s_q.err;
	assign {analog_on_o, hysteresis_level_o, hysteresis_edge_o, input_pick_o,
		alternate_input_pick_o, outside_reference_pick_o, ref_out_drive_o,
		span_o, threshold_code_o} = s_q.ana;
	assign {compare_out_o, irq_o, adc_trigger_o, pwm_duty_cut_o,
		pwm_period_cut_o, wake_o} = s_q.outs;
	assign pwm_fault_o = s_q.fault;
endmodule

// ==== test/cdc_props.sv ====
// port assertions for the comparator control block
`timescale 1ns/1ps
module cdc_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// channel
	input wire logic idle_i,
	input wire logic sleep_i,
	input wire logic analog_on_o,
	input wire logic ref_out_drive_o,
	input wire logic compare_out_o,
	input wire logic irq_o,
	input wire logic wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	ready_next_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	err_map_a: assert property (psel_i && !penable_i && paddr_i > 12'h008 |=> pslverr_o)
		else $error("unmapped not refused");
	upper_zero_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	stretch_min_a: assert property ($rose(compare_out_o) |-> compare_out_o [*3])
		else $error("output pulse too short");
	irq_pulse_a: assert property (irq_o |=> !irq_o)
		else $error("irq longer than a cycle");
	wake_gate_a: assert property (wake_o |-> idle_i || sleep_i || $past(idle_i) || $past(sleep_i))
		else $error("wake while awake");
	ref_run_a: assert property (ref_out_drive_o |-> analog_on_o)
		else $error("reference out while off");
endmodule
// .* keeps the bind in step with the port list above
bind cdc_top cdc_props i_cdc_props (.*);

// ==== test/tb_comparator_digital_control.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_comparator_digital_control;
	logic clk_i = '0, reset_n_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0;
	logic idle_i = '0, sleep_i = '0, compare_raw_i = '0, err;
	logic [11:0] paddr_i = '0, threshold_code_o;
	logic [31:0] pwdata_i = '0, prdata_o, rdat;
	logic pready_o, pslverr_o, analog_on_o, hysteresis_edge_o, alternate_input_pick_o;
	logic outside_reference_pick_o, ref_out_drive_o, span_o, compare_out_o, irq_o;
	logic adc_trigger_o, pwm_duty_cut_o, pwm_period_cut_o, pwm_fault_o, wake_o;
	logic [1:0] hysteresis_level_o, input_pick_o;
	logic [4:0] seen;
	int fail_count = 0, n_checks = 0, n;
	cdc_top i_cdc_top (.*);
	always #50 clk_i = ~clk_i;
	task complete_run;
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] s, e, input string nm);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	// one clock of gap after release so no strobe is driven twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do @(posedge clk_i); while (pready_o !== 1'h1);
		rdat = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'h0, a, 32'h0);
		chk(rdat, e, nm);
	endtask
	task t_reset;
		rd(12'h000, 32'h0, "ctrl");
		rd(12'h004, 32'h0, "thresh");
		rd(12'h008, 32'h0, "dest");
	endtask
	task t_fields;
		apb(1'h1, 12'h000, 32'hffffffff);
		repeat (8) @(posedge clk_i);
		rd(12'h000, 32'h0000bfff, "ctrl");
		chk({hysteresis_level_o, hysteresis_edge_o, input_pick_o}, 32'h1f, "hyst");
		chk({alternate_input_pick_o, outside_reference_pick_o, span_o}, 32'h7, "ref");
		chk(compare_out_o, 32'h1, "inverted");
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, 12'h000, 32'h8001 | (i << 11) | (i << 6));
			@(posedge clk_i);
			chk({hysteresis_level_o, input_pick_o}, i * 5, "pick");
		end
	endtask
	task t_thresh;
		apb(1'h1, 12'h004, 32'hfffffabc);
		rd(12'h004, 32'habc, "thresh");
		chk(threshold_code_o, 32'habc, "code");
		apb(1'h0, 12'h00c, 32'h0);
		chk(err, 32'h1, "slverr");
	endtask
	task lat(input logic [31:0] c);
		apb(1'h1, 12'h000, c);
		repeat (6) @(posedge clk_i);
		compare_raw_i <= 1'h1;
		n = 0;
		while (compare_out_o !== 1'h1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		compare_raw_i <= 1'h0;
		repeat (30) @(posedge clk_i);
	endtask
	task t_filter;
		lat(32'h8201);
		chk(n >= 1 && n <= 2, 32'h1, "bypass");
		lat(32'h8601);
		chk(n >= 4 && n < 40, 32'h1, "filter");
		lat(32'h8401);
		chk(n >= 8 && n < 40, 32'h1, "slow filter");
	endtask
	task t_pulse;
		apb(1'h1, 12'h008, 32'h1f);
		apb(1'h1, 12'h000, 32'h8201);
		sleep_i <= 1'h1;
		compare_raw_i <= 1'h1;
		@(posedge clk_i);
		compare_raw_i <= 1'h0;
		n = 0;
		seen = '0;
		repeat (12) begin
			@(posedge clk_i);
			n += compare_out_o;
			seen |= {irq_o, adc_trigger_o, pwm_duty_cut_o, pwm_period_cut_o, wake_o};
		end
		chk(n >= 3, 32'h1, "stretch");
		chk(compare_out_o, 32'h0, "released");
		chk(seen, 32'h1f, "dests");
		chk(pwm_fault_o, 32'h1, "fault");
		sleep_i <= 1'h0;
		apb(1'h1, 12'h008, 32'h0);
		@(posedge clk_i);
		chk(pwm_fault_o, 32'h0, "fault clear");
	endtask
	task t_idle;
		idle_i <= 1'h1;
		apb(1'h1, 12'h000, 32'ha101);
		repeat (3) @(posedge clk_i);
		chk({analog_on_o, ref_out_drive_o}, 32'h0, "halt");
		apb(1'h1, 12'h000, 32'h8101);
		repeat (3) @(posedge clk_i);
		chk({analog_on_o, ref_out_drive_o}, 32'h3, "run");
		idle_i <= 1'h0;
		apb(1'h1, 12'h000, 32'h1);
		repeat (3) @(posedge clk_i);
		chk(analog_on_o, 32'h0, "off");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'h1;
		@(posedge clk_i);
		t_reset;
		t_fields;
		t_thresh;
		t_filter;
		t_pulse;
		t_idle;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		complete_run;
	end
endmodule
